// [rtl/udc_pkg.sv]
// udc_pkg: shared constants, register map and decode function of the up/down counter block
package udc_pkg;

  // counter geometry
  localparam int UDC_CNT_W = 4;                 // count width in bits
  localparam int UDC_IRQ_N = 3;                 // number of interrupt sources

  // apb register byte offsets
  localparam logic [7:0] UDC_OFF_CTRL     = 8'h00;  // source select and software pin levels
  localparam logic [7:0] UDC_OFF_PRELOAD  = 8'h04;  // software preload data
  localparam logic [7:0] UDC_OFF_STATUS   = 8'h08;  // live count, terminal and ripple state
  localparam logic [7:0] UDC_OFF_INT_STAT = 8'h0C;  // sticky event bits, read only
  localparam logic [7:0] UDC_OFF_INT_EN   = 8'h10;  // interrupt enable mask
  localparam logic [7:0] UDC_OFF_INT_CLR  = 8'h14;  // write one to clear, write only

  // control register fields
  localparam int UDC_CTRL_W      = 5;             // implemented control bits
  localparam int UDC_CTRL_SRC    = 0;             // 1: software drives the counter inputs
  localparam int UDC_CTRL_LOAD_N = 1;             // software parallel load, active low
  localparam int UDC_CTRL_CE_N   = 2;             // software count enable, active low
  localparam int UDC_CTRL_DOWN   = 3;             // software direction, 1 = down
  localparam int UDC_CTRL_CLK    = 4;             // software count clock level
  localparam logic [UDC_CTRL_W-1:0] UDC_CTRL_RST = 5'h06;  // pins selected, load and enable idle

  // status register fields
  localparam int UDC_STAT_TC   = 4;               // terminal count level
  localparam int UDC_STAT_RC_N = 5;               // ripple clock level
  localparam int UDC_STAT_DOWN = 6;               // direction in effect

  // interrupt bit positions
  localparam int UDC_IRQ_TC   = 0;                // terminal count became high
  localparam int UDC_IRQ_WRAP = 1;                // a step left the terminal value
  localparam int UDC_IRQ_LOAD = 2;                // a parallel load began

  // reset values
  localparam logic [UDC_CNT_W-1:0] UDC_PRELOAD_RST = 4'h0;
  localparam logic [UDC_IRQ_N-1:0] UDC_INT_EN_RST  = 3'h0;

  // terminal value for the selected direction: all ones going up, zero going down
  function automatic logic udc_term(input logic [UDC_CNT_W-1:0] v, input logic down);
    logic hit;
    hit = down ? (v == {UDC_CNT_W{1'b0}}) : (v == {UDC_CNT_W{1'b1}});
    return hit;
  endfunction : udc_term

endpackage : udc_pkg

// [rtl/udc_step_core.sv]
// udc_step_core: count register with load, hold and up/down stepping
`timescale 1ns/1ns
module udc_step_core #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // counter controls
  input  wire logic         load_n,
  input  wire logic [W-1:0] preload,
  input  wire logic         ce_n,
  input  wire logic         down,
  input  wire logic         cnt_clk,
  // results
  output logic [W-1:0]      count_value,
  output logic              wrap_pulse
);

  logic [W-1:0] count_r;        // stored count, all bits in one register
  logic [W-1:0] count_nxt;      // next count
  logic         clk_prev_r;     // count clock level at the previous edge
  logic         rise;           // rising edge of the count clock seen this cycle
  logic         step;           // a step is taken this cycle
  logic [W-1:0] one_w;          // constant one at count width

  assign one_w = {{(W-1){1'b0}}, 1'b1};
  assign rise  = cnt_clk & ~clk_prev_r;
  // load blocks stepping; a high enable holds the count
  assign step  = load_n & ~ce_n & rise;                          // RULE3 RULE4
  // modulo wrap falls out of the fixed width arithmetic
  assign count_nxt = !load_n ? preload :                         // RULE2
                     !step   ? count_r :
                     down    ? count_r - one_w : count_r + one_w; // RULE5 RULE17
  // load shows at the output at once, without waiting for an edge
  assign count_value = load_n ? count_r : preload;               // RULE2
  // leaving the terminal value by a step is a wrap
  assign wrap_pulse  = step & udc_pkg::udc_term(count_r, down);

  // all count bits update together on the one edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r    <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      count_r    <= count_nxt;                                   // RULE1 RULE6
      clk_prev_r <= cnt_clk;
    end
  end

  hold_count_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    load_n && ce_n |=> count_r == $past(count_r))
    else $error("count moved while enable was high");
  step_dir_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    step |=> count_r == ($past(down) ? $past(count_r) - one_w : $past(count_r) + one_w))
    else $error("step went the wrong way");
  wrap_up_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    step && !down && count_r == {W{1'b1}} |=> count_r == '0)
    else $error("up count did not wrap to zero");
  edge_only_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    load_n && !rise |=> $stable(count_r))
    else $error("count changed without a clock rise");

endmodule : udc_step_core

// [rtl/udc_irq_bank.sv]
// udc_irq_bank: sticky event bits, enable mask and level interrupt
`timescale 1ns/1ns
module udc_irq_bank #(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // events and software controls
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic [N-1:0] en_i,
  // state
  output logic [N-1:0]      stat_o,
  output logic              irq_o
);

  logic [N-1:0] stat_r;   // sticky status
  logic [N-1:0] stat_nxt; // set beats a clear in the same cycle

  assign stat_nxt = set_i | (stat_r & ~clr_i);
  assign stat_o   = stat_r;
  assign irq_o    = |(stat_r & en_i);

  // sticky bits survive until software clears them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    |set_i |=> (stat_r & $past(set_i)) == $past(set_i))
    else $error("event lost against a clear");

endmodule : udc_irq_bank

// [rtl/udc_counter_top.sv]
// udc_counter_top: presettable 4-bit up/down counter with apb control and interrupts
`timescale 1ns/1ns
//
// Overview of operation
// RULE1: hold a presettable 4-bit up/down binary count
// RULE2: low load copies preload to count immediately
// RULE3: load overrides clock, direction and enable
// RULE4: high enable holds the count
// RULE5: enabled clock rise steps up or down
// RULE6: all count bits change together
// RULE7: terminal high at 15 up, 0 down
// RULE8: terminal holds until count or direction changes
// RULE9: enable never affects terminal count
// RULE10: ripple low during clock low at terminal
// RULE11: high enable keeps ripple output high
// RULE12: ripple returns high when clock rises
// RULE13: outside logic must not clock from terminal
// RULE14: ripple output may clock next stage
// RULE15: shared clock low must cover ripple chain
// RULE16: lookahead gates preceding terminals into enables
// RULE17: counting wraps modulo sixteen
module udc_counter_top #(
  parameter int W = udc_pkg::UDC_CNT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // counter pins
  input  wire logic         parallel_load_n,
  input  wire logic [W-1:0] preload_value,
  input  wire logic         count_enable_n,
  input  wire logic         down_sel,
  input  wire logic         count_clock,
  // counter outputs
  output logic [W-1:0]      count_value,
  output logic              terminal_count,
  output logic              ripple_clock_n,
  // interrupt
  output logic              irq
);

  localparam int N = udc_pkg::UDC_IRQ_N;

  // software registers
  logic [udc_pkg::UDC_CTRL_W-1:0] ctrl_r;      // source select and software levels
  logic [W-1:0]                   preload_r;   // software preload data
  logic [N-1:0]                   int_en_r;    // interrupt mask
  logic [31:0]                    prdata_r;    // read data caught in the setup cycle

  // effective counter inputs after source selection
  logic         src_sw;     // software drives the counter
  logic         eff_load_n; // parallel load, active low
  logic [W-1:0] eff_pre;    // preload data
  logic         eff_ce_n;   // count enable, active low
  logic         eff_down;   // direction, 1 = down
  logic         eff_clk;    // count clock level

  // event detection
  logic         term_prev_r; // terminal level one cycle ago
  logic         load_prev_r; // load level one cycle ago
  logic         wrap_pulse;  // a step left the terminal value
  logic [N-1:0] ev_set;      // events into the sticky bank
  logic [N-1:0] ev_clr;      // clears from software
  logic [N-1:0] int_stat;    // sticky status

  // apb decode
  logic         setup_ph;    // first cycle of a transfer
  logic         acc_wr;      // write takes effect this edge
  logic         hit_ctrl;
  logic         hit_pre;
  logic         hit_stat;
  logic         hit_istat;
  logic         hit_ien;
  logic         hit_iclr;
  logic         hit_any;     // address is mapped
  logic [31:0]  rd_mux;      // read data for the addressed register
  logic [31:0]  status_word; // assembled status view

  // source selection: the register can take the pins over, which lets software
  // exercise the counter when nothing outside drives it
  assign src_sw     = ctrl_r[udc_pkg::UDC_CTRL_SRC];
  assign eff_load_n = src_sw ? ctrl_r[udc_pkg::UDC_CTRL_LOAD_N] : parallel_load_n;
  assign eff_pre    = src_sw ? preload_r : preload_value;
  assign eff_ce_n   = src_sw ? ctrl_r[udc_pkg::UDC_CTRL_CE_N] : count_enable_n;
  assign eff_down   = src_sw ? ctrl_r[udc_pkg::UDC_CTRL_DOWN] : down_sel;
  assign eff_clk    = src_sw ? ctrl_r[udc_pkg::UDC_CTRL_CLK] : count_clock;

  // count register, load path and stepping
  udc_step_core #(
    .W (W)
  ) u_core (
    .clk         (clk),
    .rst_n       (rst_n),
    .load_n      (eff_load_n),
    .preload     (eff_pre),
    .ce_n        (eff_ce_n),
    .down        (eff_down),
    .cnt_clk     (eff_clk),
    .count_value (count_value),
    .wrap_pulse  (wrap_pulse)
  );

  // terminal decode looks at the visible count and direction only; it is a
  // decode, so it can spike while bits settle and must not serve as a clock
  assign terminal_count = udc_pkg::udc_term(count_value, eff_down);     // RULE7 RULE9 RULE13

  // ripple output copies the low phase of the count clock at terminal,
  // gated by the enable, and releases as soon as the clock rises
  assign ripple_clock_n = ~(terminal_count & ~eff_ce_n & ~eff_clk);    // RULE10 RULE11 RULE12

  // events: terminal reached, wrap, and the start of a load
  assign ev_set[udc_pkg::UDC_IRQ_TC]   = terminal_count & ~term_prev_r;
  assign ev_set[udc_pkg::UDC_IRQ_WRAP] = wrap_pulse;
  assign ev_set[udc_pkg::UDC_IRQ_LOAD] = ~eff_load_n & load_prev_r;

  // previous levels for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_prev_r <= 1'b0;
      load_prev_r <= 1'b1;
    end else begin
      term_prev_r <= terminal_count;
      load_prev_r <= eff_load_n;
    end
  end

  // sticky status, mask and level interrupt
  udc_irq_bank #(
    .N (N)
  ) u_irq (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_i  (ev_set),
    .clr_i  (ev_clr),
    .en_i   (int_en_r),
    .stat_o (int_stat),
    .irq_o  (irq)
  );

  // apb address decode
  assign setup_ph  = psel & ~penable;
  assign acc_wr    = psel & penable & pwrite;
  assign hit_ctrl  = (paddr == udc_pkg::UDC_OFF_CTRL);
  assign hit_pre   = (paddr == udc_pkg::UDC_OFF_PRELOAD);
  assign hit_stat  = (paddr == udc_pkg::UDC_OFF_STATUS);
  assign hit_istat = (paddr == udc_pkg::UDC_OFF_INT_STAT);
  assign hit_ien   = (paddr == udc_pkg::UDC_OFF_INT_EN);
  assign hit_iclr  = (paddr == udc_pkg::UDC_OFF_INT_CLR);
  assign hit_any   = hit_ctrl | hit_pre | hit_stat | hit_istat | hit_ien | hit_iclr;

  // clear register is write only; a set in the same cycle still wins
  assign ev_clr = (acc_wr && hit_iclr) ? pwdata[N-1:0] : '0;

  // status view of the live counter
  assign status_word = {25'h0, eff_down, ripple_clock_n, terminal_count, count_value};

  // read mux; write-only and unmapped addresses read as zero
  assign rd_mux = hit_ctrl  ? {27'h0, ctrl_r} :
                  hit_pre   ? {28'h0, preload_r} :
                  hit_stat  ? status_word :
                  hit_istat ? {29'h0, int_stat} :
                  hit_ien   ? {29'h0, int_en_r} :
                  32'h00000000;

  // zero wait states; the error flag only matters in the access phase
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_r;

  // software writes land at the access edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r    <= udc_pkg::UDC_CTRL_RST;
      preload_r <= udc_pkg::UDC_PRELOAD_RST;
      int_en_r  <= udc_pkg::UDC_INT_EN_RST;
    end else if (acc_wr) begin
      if (hit_ctrl) ctrl_r    <= pwdata[udc_pkg::UDC_CTRL_W-1:0];
      if (hit_pre)  preload_r <= pwdata[W-1:0];
      if (hit_ien)  int_en_r  <= pwdata[N-1:0];
    end
  end

  // read data caught in the setup cycle so it is stable through the access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // checks on the outputs
  tc_decode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    terminal_count == ((eff_down && count_value == 4'h0) || (!eff_down && count_value == 4'hF)))
    else $error("terminal count does not match count and direction");
  tc_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    terminal_count ##1 ($stable(count_value) && $stable(eff_down)) |-> terminal_count)
    else $error("terminal count fell with count and direction unchanged");
  tc_no_ce_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    $changed(eff_ce_n) && $stable(count_value) && $stable(eff_down) |-> $stable(terminal_count))
    else $error("enable changed the terminal count");
  rc_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    terminal_count && !eff_ce_n && !eff_clk |-> !ripple_clock_n)
    else $error("ripple output missing during the low phase");
  rc_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    eff_ce_n |-> ripple_clock_n)
    else $error("ripple pulse while disabled");
  rc_release_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    !ripple_clock_n ##1 eff_clk |-> ripple_clock_n)
    else $error("ripple output stayed low after the clock rose");
  load_now_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    !eff_load_n |-> count_value == eff_pre)
    else $error("load value not visible at once");
  load_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    !eff_load_n ##1 !eff_load_n |-> count_value == eff_pre && $past(count_value) == $past(eff_pre))
    else $error("count moved during a load");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(int_stat & int_en_r))
    else $error("interrupt does not follow masked status");
  unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !hit_any |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // main scenarios
  up_wrap_c:   cover property (@(posedge clk) disable iff (!rst_n)
    wrap_pulse && !eff_down);
  down_wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
    wrap_pulse && eff_down);
  rc_pulse_c:  cover property (@(posedge clk) disable iff (!rst_n)
    ripple_clock_n ##1 !ripple_clock_n ##1 ripple_clock_n);
  load_irq_c:  cover property (@(posedge clk) disable iff (!rst_n)
    ev_set[udc_pkg::UDC_IRQ_LOAD] ##1 irq);

endmodule : udc_counter_top

// [test/udc_far_model.sv]
// udc_far_model: controlling logic that drives the counter pins of one stage
`timescale 1ns/1ns
module udc_far_model (
  // clock
  input  wire logic clk,
  // counter pins
  output logic       parallel_load_n,
  output logic [3:0] preload_value,
  output logic       count_enable_n,
  output logic       down_sel,
  output logic       count_clock
);
  logic [3:0] pre_r;    // data held for a load
  logic [3:0] churn_r;  // junk pattern shown while no load is asked

  // idle levels: no load, counting off, clock parked low
  initial begin
    parallel_load_n = 1'b1;
    pre_r = 4'h0;
    churn_r = 4'h0;
    count_enable_n = 1'b1;
    down_sel = 1'b0;
    count_clock = 1'b0;
  end

  // data lines mean nothing outside a load, so never leave a stale value on them
  assign preload_value = parallel_load_n ? churn_r : pre_r;

  // churn changes every cycle
  always @(posedge clk) begin
    churn_r <= churn_r + 4'h7;
  end

  // new levels just after an edge; single stage, so enable is the global enable
  task automatic drive(input logic ld_n, input logic [3:0] d, input logic ce_n,
                       input logic dn);
    @(posedge clk);
    parallel_load_n <= ld_n;
    pre_r <= d;
    count_enable_n <= ce_n;
    down_sel <= dn;
  endtask : drive

  // one count clock period, high and low one cycle each, then parked low;
  // terminal_count is never used as a clock here
  // ripple_clock_n clocks no next stage, so no chain delay to cover
  task automatic pulse();
    @(posedge clk);
    count_clock <= 1'b1;
    @(posedge clk);
    count_clock <= 1'b0;
    @(posedge clk);
  endtask : pulse
endmodule : udc_far_model

// [test/tb.sv]
// tb: self-checking bench for the up/down counter with apb control
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb;
  typedef struct packed { logic k; logic [32:0] v; } udc_exp_s;
  logic        clk;             // system clock
  logic        rst_n;           // sync reset
  logic        psel;            // apb request
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  count_value;     // counter outputs
  logic        terminal_count;
  logic        ripple_clock_n;
  logic        irq;
  wire logic   pl_n;            // pins from the far model
  wire logic   ce_n;
  wire logic   dn;
  wire logic   cclk;
  wire logic [3:0] pre;
  int          errors;
  int          n_compared;
  int          cyc;             // timeout counter
  logic [31:0] seed;
  logic [31:0] b;               // random word
  logic [31:0] rd_r;            // last read data
  logic        err_r;           // last slave error
  logic [3:0]  m;               // model count
  logic        t;               // model terminal
  udc_exp_s    q[$];            // expected results, oldest first
  udc_exp_s    e;

  udc_counter_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parallel_load_n(pl_n),
    .preload_value(pre), .count_enable_n(ce_n), .down_sel(dn),
    .count_clock(cclk), .count_value(count_value),
    .terminal_count(terminal_count), .ripple_clock_n(ripple_clock_n), .irq(irq));
  udc_far_model far (.clk(clk), .parallel_load_n(pl_n), .preload_value(pre),
    .count_enable_n(ce_n), .down_sel(dn), .count_clock(cclk));

  // 50 ns clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // verdict and end of run
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // checker: settled outputs are compared at the falling edge
  always @(negedge clk) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      if (e.k) `CHK({err_r, rd_r}, e.v)
      else `CHK({irq, ripple_clock_n, terminal_count, count_value}, e.v[6:0])
    end
  end

  // apb transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench's hang guard may end this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd_r = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // read and note the expected word and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic er);
    apb(1'b0, a, 32'h0);
    q.push_back({1'b1, er, x});
  endtask : rd

  // note expected pins
  function automatic void pins(input logic [3:0] c, input logic tc, input logic rcn,
                               input logic iq);
    q.push_back({1'b0, 26'h0, iq, rcn, tc, c});
  endfunction : pins

  // main sequence
  initial begin
    seed = 32'h3C65;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    pins(4'h0, 1'b0, 1'b1, 1'b0);
    // reset values, a read-only write and an unmapped place
    rd(udc_pkg::UDC_OFF_CTRL, 32'h6, 1'b0);
    rd(udc_pkg::UDC_OFF_PRELOAD, 32'h0, 1'b0);
    rd(udc_pkg::UDC_OFF_INT_EN, 32'h0, 1'b0);
    rd(udc_pkg::UDC_OFF_INT_STAT, 32'h0, 1'b0);
    rd(udc_pkg::UDC_OFF_INT_CLR, 32'h0, 1'b0);
    wr(udc_pkg::UDC_OFF_STATUS, 32'hFFFF);
    wr(8'h18, 32'hFF);
    rd(8'h18, 32'h0, 1'b1);
    // load shows at once and overrides a clock
    far.drive(1'b0, 4'hE, 1'b0, 1'b0);
    pins(4'hE, 1'b0, 1'b1, 1'b0);
    far.pulse();
    pins(4'hE, 1'b0, 1'b1, 1'b0);
    far.drive(1'b1, 4'h0, 1'b0, 1'b0);
    far.pulse();
    pins(4'hF, 1'b1, 1'b0, 1'b0);
    rd(udc_pkg::UDC_OFF_INT_STAT, 32'h5, 1'b0);
    // disabled: terminal stays, ripple held high, count holds
    far.drive(1'b1, 4'h0, 1'b1, 1'b0);
    pins(4'hF, 1'b1, 1'b1, 1'b0);
    far.pulse();
    pins(4'hF, 1'b1, 1'b1, 1'b0);
    far.drive(1'b1, 4'h0, 1'b0, 1'b1);
    pins(4'hF, 1'b0, 1'b1, 1'b0);
    far.drive(1'b1, 4'h0, 1'b0, 1'b0);
    far.pulse();
    pins(4'h0, 1'b0, 1'b1, 1'b0);
    // interrupt raised, masked and cleared
    rd(udc_pkg::UDC_OFF_INT_STAT, 32'h7, 1'b0);
    wr(udc_pkg::UDC_OFF_INT_EN, 32'h2);
    pins(4'h0, 1'b0, 1'b1, 1'b1);
    wr(udc_pkg::UDC_OFF_INT_EN, 32'h0);
    pins(4'h0, 1'b0, 1'b1, 1'b0);
    wr(udc_pkg::UDC_OFF_INT_CLR, 32'h7);
    rd(udc_pkg::UDC_OFF_INT_STAT, 32'h0, 1'b0);
    wr(udc_pkg::UDC_OFF_INT_EN, 32'h7);
    far.drive(1'b1, 4'h0, 1'b0, 1'b1);
    rd(udc_pkg::UDC_OFF_INT_STAT, 32'h1, 1'b0);
    pins(4'h0, 1'b1, 1'b0, 1'b1);
    far.pulse();
    pins(4'hF, 1'b0, 1'b1, 1'b1);
    wr(udc_pkg::UDC_OFF_INT_CLR, 32'h7);
    pins(4'hF, 1'b0, 1'b1, 1'b0);
    rd(udc_pkg::UDC_OFF_STATUS, 32'h6F, 1'b0);
    // software source loads through the registers
    wr(udc_pkg::UDC_OFF_PRELOAD, 32'h5);
    wr(udc_pkg::UDC_OFF_CTRL, 32'h1);
    rd(udc_pkg::UDC_OFF_STATUS, 32'h25, 1'b0);
    // software enable, direction and clock bits step the count down once
    wr(udc_pkg::UDC_OFF_CTRL, 32'h0B);
    wr(udc_pkg::UDC_OFF_CTRL, 32'h1B);
    wr(udc_pkg::UDC_OFF_CTRL, 32'h0B);
    rd(udc_pkg::UDC_OFF_STATUS, 32'h64, 1'b0);
    wr(udc_pkg::UDC_OFF_CTRL, 32'h6);
    wr(udc_pkg::UDC_OFF_INT_EN, 32'h0);
    // random steps against a modulo-sixteen model
    far.drive(1'b0, 4'h3, 1'b0, 1'b0);
    far.drive(1'b1, 4'h3, 1'b0, 1'b0);
    m = 4'h3;
    repeat (60) begin
      b = $random(seed);
      far.drive(1'b1, b[7:4], b[0], b[1]);
      far.pulse();
      if (!b[0]) m = b[1] ? m - 4'h1 : m + 4'h1;
      t = b[1] ? (m == 4'h0) : (m == 4'hF);
      pins(m, t, ~(t & ~b[0]), 1'b0);
    end
    // let the checker drain the last note before the verdict
    repeat (2) @(negedge clk);
    tally_and_finish();
  end
endmodule : tb
